// file: core/bcu_top.sv
// Branch control unit: resolves direct, conditional, compare and loop jumps.
`default_nettype none
`include "bcu_map.svh"
module bcu_top
  import bcu_pkg::*;
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic reset_i,
  // Decoded instruction, valid for one cycle
  input wire logic instr_valid_i,
  input wire bcu_pkg::bcu_op_t op_i,
  input wire logic flag_sense_i,
  input wire logic [31:0] pc_i,
  input wire logic [31:0] offset_i,
  input wire logic [31:0] src1_i,
  input wire logic [31:0] src2_i,
  // Condition flag from the integer unit
  input wire logic condition_flag_i,
  // Trap reported on the current instruction
  input wire logic trap_i,
  // Fetch control
  output logic redirect_o,
  output logic [31:0] target_o,
  output logic annul_o,
  output logic [31:0] resume_pc_o,
  // Counter write-back
  output logic wb_valid_o,
  output logic [31:0] wb_data_o,
  // Flags
  output logic loop_condition_flag_o,
  output logic loop_trap_indicator_o
);
  import bcu_pkg::*;

  // ----------------------------------------------------------------
  // Decision
  // ----------------------------------------------------------------
  bcu_dec_if dec ();
  logic slot_r;
  logic [31:0] slot_target_r;
  logic loop_slot_r;
  logic loop_pend_r;
  logic [31:0] loop_pc_r;
  logic slot_is_instr;
  logic in_slot;
  logic is_loop;

  bcu_resolver bcu_resolver_i (
    .op_i(op_i),
    .flag_sense_i(flag_sense_i),
    .pc_i(pc_i),
    .offset_i(offset_i),
    .src1_i(src1_i),
    .src2_i(src2_i),
    .condition_flag_i(condition_flag_i),
    .loop_condition_flag_i(loop_condition_flag_o),
    .dec(dec)
  );

  // The delay slot is trusted to be no transfer, so a branch seen in it is ignored.
  assign in_slot = slot_r | loop_slot_r;
  assign slot_is_instr = instr_valid_i & in_slot;
  assign is_loop = instr_valid_i & ~in_slot & (op_i == BCU_OP_LOOP_ADD);

  // ----------------------------------------------------------------
  // Delay slot tracking
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      slot_r <= 1'b0;
      slot_target_r <= `BCU_PC_RESET;
    end
    else if (slot_is_instr | trap_i)
      slot_r <= 1'b0;
    else if (instr_valid_i & dec.redirect & dec.delayed)
    begin
      slot_r <= 1'b1;
      slot_target_r <= dec.target;
    end
  end

  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      loop_slot_r <= 1'b0;
      loop_pend_r <= 1'b0;
      loop_pc_r <= `BCU_PC_RESET;
    end
    else if (is_loop & ~trap_i)
    begin
      loop_slot_r <= 1'b1;
      loop_pend_r <= dec.pend;
      loop_pc_r <= pc_i;
    end
    else if (slot_is_instr | trap_i)
      loop_slot_r <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Fetch redirect and annul
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      redirect_o <= 1'b0;
      target_o <= `BCU_PC_RESET;
      annul_o <= 1'b0;
    end
    else
    begin
      redirect_o <= 1'b0;
      annul_o <= 1'b0;
      if (trap_i)
        redirect_o <= 1'b0;
      else if (slot_is_instr & slot_r)
      begin
        redirect_o <= 1'b1;
        target_o <= slot_target_r;
      end
      else if (instr_valid_i & ~in_slot & dec.redirect & ~dec.delayed)
      begin
        redirect_o <= 1'b1;
        target_o <= dec.target;
      end
      else if (instr_valid_i & ~in_slot & dec.annul)
        annul_o <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Loop flag, write-back and trap handling
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
      loop_condition_flag_o <= `BCU_LOOP_FLAG_RESET;
    else if (slot_is_instr & loop_slot_r & ~trap_i)
      loop_condition_flag_o <= loop_pend_r;
  end

  // Sum is marked valid only when the loop add itself does not trap, so a restart recomputes cleanly.
  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      wb_valid_o <= 1'b0;
      wb_data_o <= `BCU_PC_RESET;
    end
    else
    begin
      wb_valid_o <= is_loop & ~trap_i;
      if (is_loop)
        wb_data_o <= dec.sum;
    end
  end

  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
      resume_pc_o <= `BCU_PC_RESET;
    else if (trap_i & (loop_slot_r | is_loop))
      resume_pc_o <= loop_slot_r ? loop_pc_r : pc_i;
    else if (trap_i & instr_valid_i)
      resume_pc_o <= pc_i;
  end

  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
      loop_trap_indicator_o <= `BCU_TRAP_IND_RESET;
    else if (trap_i & is_loop)
      loop_trap_indicator_o <= 1'b1;
    else if (instr_valid_i & ~trap_i)
      loop_trap_indicator_o <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_loop_issue;
    is_loop & ~trap_i;
  endsequence

  a_loop_flag_hold: assert property (@(posedge clock_i) disable iff (reset_i)
    trap_i |=> $stable(loop_condition_flag_o))
    else $error("Loop flag changed on trap.");
  a_loop_trap_ind: assert property (@(posedge clock_i) disable iff (reset_i)
    (trap_i & is_loop) |=> loop_trap_indicator_o)
    else $error("Loop trap indicator not set.");
  a_loop_resume_pc: assert property (@(posedge clock_i) disable iff (reset_i)
    (trap_i & is_loop) |=> resume_pc_o == $past(pc_i))
    else $error("Resume address is not the loop add.");
  a_loop_wb_sum: assert property (@(posedge clock_i) disable iff (reset_i)
    s_loop_issue |=> wb_valid_o && wb_data_o == $past(src1_i) + $past(src2_i))
    else $error("Loop sum not written back.");
  a_annul_untaken: assert property (@(posedge clock_i) disable iff (reset_i)
    (instr_valid_i & ~in_slot & ~trap_i & op_i == BCU_OP_JUMP_ON_FLAG_DELAYED & ~dec.flag_ok) |=> annul_o)
    else $error("Untaken delayed jump did not annul.");
  a_nodelay_jump: assert property (@(posedge clock_i) disable iff (reset_i)
    (instr_valid_i & ~in_slot & ~trap_i & op_i == BCU_OP_JUMP_ON_FLAG & dec.flag_ok)
    |=> redirect_o && target_o == $past(pc_i) + 32'h0000_0004 + $past(offset_i))
    else $error("Flag jump target wrong.");
  a_untaken_plain: assert property (@(posedge clock_i) disable iff (reset_i)
    (instr_valid_i & ~in_slot & op_i == BCU_OP_JUMP_ON_FLAG & ~dec.flag_ok) |=> !redirect_o && !annul_o)
    else $error("Untaken flag jump disturbed flow.");
  a_delay_wait: assert property (@(posedge clock_i) disable iff (reset_i)
    (instr_valid_i & ~in_slot & ~trap_i & op_i == BCU_OP_JUMP_ALWAYS_DELAYED) |=> !redirect_o)
    else $error("Delayed jump did not wait for its slot.");
  a_compare_eq: assert property (@(posedge clock_i) disable iff (reset_i)
    (instr_valid_i & ~in_slot & ~trap_i & op_i == BCU_OP_COMPARE_EQUAL) |=> redirect_o == $past(src1_i == src2_i))
    else $error("Equal compare decision wrong.");
  a_loop_flag_upd: assert property (@(posedge clock_i) disable iff (reset_i)
    s_loop_issue ##1 (slot_is_instr & ~trap_i) |=> loop_condition_flag_o == ~$past(wb_data_o[31]))
    else $error("Loop flag not taken from sum sign.");
endmodule
`default_nettype wire

// file: core/bcu_map.svh
// Constants for the branch control unit.
`ifndef BCU_MAP_SVH
`define BCU_MAP_SVH
`define BCU_PC_STEP 32'h0000_0004
`define BCU_FLAG_RESET 1'h0
`define BCU_LOOP_FLAG_RESET 1'h0
`define BCU_TRAP_IND_RESET 1'h0
`define BCU_PC_RESET 32'h0000_0000
`endif

// file: core/bcu_pkg.sv
// Types shared by the branch control unit.
`default_nettype none
package bcu_pkg;
  typedef enum logic [2:0] {
    BCU_OP_NONE,
    BCU_OP_JUMP_ALWAYS_DELAYED,
    BCU_OP_JUMP_ON_FLAG,
    BCU_OP_JUMP_ON_FLAG_DELAYED,
    BCU_OP_COMPARE_EQUAL,
    BCU_OP_COMPARE_UNEQUAL,
    BCU_OP_LOOP_ADD
  } bcu_op_t;
endpackage
`default_nettype wire

// file: core/bcu_if.sv
// Interface carrying resolved decisions from the resolver to the top.
`default_nettype none
interface bcu_dec_if;
  logic redirect;
  logic [31:0] target;
  logic delayed;
  logic annul;
  logic flag_ok;
  logic [31:0] sum;
  logic pend;
  modport res (output redirect, output target, output delayed, output annul, output flag_ok, output sum, output pend);
  modport top (input redirect, input target, input delayed, input annul, input flag_ok, input sum, input pend);
endinterface
`default_nettype wire

// file: core/bcu_resolver.sv
// Combinational branch decision for one decoded instruction.
`default_nettype none
`include "bcu_map.svh"
module bcu_resolver
  import bcu_pkg::*;
(
  // Instruction
  input wire bcu_pkg::bcu_op_t op_i,
  input wire logic flag_sense_i,
  input wire logic [31:0] pc_i,
  input wire logic [31:0] offset_i,
  input wire logic [31:0] src1_i,
  input wire logic [31:0] src2_i,
  // Flags
  input wire logic condition_flag_i,
  input wire logic loop_condition_flag_i,
  // Decision
  bcu_dec_if.res dec
);
  logic [31:0] sum_w;
  assign sum_w = src1_i + src2_i;
  // Target is own address plus four plus offset.
  assign dec.target = pc_i + `BCU_PC_STEP + offset_i;
  assign dec.flag_ok = (condition_flag_i == flag_sense_i);
  assign dec.sum = sum_w;
  assign dec.pend = ~sum_w[31];
  always_comb
  begin
    dec.redirect = 1'b0;
    dec.delayed = 1'b0;
    dec.annul = 1'b0;
    case (op_i)
      BCU_OP_JUMP_ALWAYS_DELAYED:
      begin
        dec.redirect = 1'b1;
        dec.delayed = 1'b1;
      end
      BCU_OP_JUMP_ON_FLAG: dec.redirect = dec.flag_ok;
      BCU_OP_JUMP_ON_FLAG_DELAYED:
      begin
        dec.redirect = dec.flag_ok;
        dec.delayed = dec.flag_ok;
        dec.annul = ~dec.flag_ok;
      end
      BCU_OP_COMPARE_EQUAL: dec.redirect = (src1_i == src2_i);
      BCU_OP_COMPARE_UNEQUAL: dec.redirect = (src1_i != src2_i);
      BCU_OP_LOOP_ADD:
      begin
        dec.redirect = loop_condition_flag_i;
        dec.delayed = loop_condition_flag_i;
      end
      default: dec.redirect = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

// file: tb/bcu_top_test.sv
// Self-checking bench for the branch control unit.
`default_nettype none
module bcu_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  import bcu_pkg::*;

  // ----------------------------------------
  // Design under test
  // ----------------------------------------
  logic clock_i = 1'b0;
  logic reset_i = 1'b1;
  logic instr_valid_i = 1'b0;
  bcu_op_t op_i = BCU_OP_NONE;
  logic flag_sense_i = 1'b0;
  logic condition_flag_i = 1'b0;
  logic trap_i = 1'b0;
  logic [31:0] pc_i = 32'h0000_0000;
  logic [31:0] offset_i = 32'h0000_0000;
  logic [31:0] src1_i = 32'h0000_0000;
  logic [31:0] src2_i = 32'h0000_0000;
  logic redirect_o, annul_o, wb_valid_o, loop_condition_flag_o, loop_trap_indicator_o;
  logic [31:0] target_o, resume_pc_o, wb_data_o;
  int err_count = 0;
  int cmp_count = 0;
  logic lf = 1'b0;
  logic went;
  int n, it;
  logic [31:0] cnt, a;

  bcu_top bcu_top_i (.clock_i, .reset_i, .instr_valid_i, .op_i, .flag_sense_i, .pc_i, .offset_i, .src1_i,
    .src2_i, .condition_flag_i, .trap_i, .redirect_o, .target_o, .annul_o, .resume_pc_o, .wb_valid_o,
    .wb_data_o, .loop_condition_flag_o, .loop_trap_indicator_o);

  always #2 clock_i = ~clock_i;

  // ----------------------------------------
  // Checking helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // One instruction followed by a plain slot instruction; the model predicts both cycles.
  task automatic xfer(input bcu_op_t o, input logic sn, input logic cf, input logic [31:0] s1,
                      input logic [31:0] s2, input logic ta, input logic ts);
    logic [31:0] p, f, tgt, sum;
    logic tk, dl;
    p = 32'h4000_0000 + ($urandom & 32'h0fff_fffc);
    f = ($urandom & 32'h0000_0ffc) - 32'h0000_0800;
    tgt = p + 32'h0000_0004 + f;
    sum = s1 + s2;
    dl = (o == BCU_OP_JUMP_ALWAYS_DELAYED) || (o == BCU_OP_JUMP_ON_FLAG_DELAYED) || (o == BCU_OP_LOOP_ADD);
    case (o)
      BCU_OP_JUMP_ON_FLAG, BCU_OP_JUMP_ON_FLAG_DELAYED: tk = (cf == sn);
      BCU_OP_COMPARE_EQUAL: tk = (s1 == s2);
      BCU_OP_COMPARE_UNEQUAL: tk = (s1 != s2);
      BCU_OP_JUMP_ALWAYS_DELAYED: tk = 1'b1;
      BCU_OP_LOOP_ADD: tk = lf && !ta && !ts;
      default: tk = 1'b0;
    endcase
    @(posedge clock_i);
    instr_valid_i <= 1'b1;
    op_i <= o;
    flag_sense_i <= sn;
    condition_flag_i <= cf;
    pc_i <= p;
    offset_i <= f;
    src1_i <= s1;
    src2_i <= s2;
    trap_i <= ta;
    @(posedge clock_i);
    op_i <= BCU_OP_NONE;
    pc_i <= p + 32'h0000_0004;
    trap_i <= ts;
    @(negedge clock_i);
    chk(redirect_o, 32'(!dl && tk));
    chk(annul_o, 32'(o == BCU_OP_JUMP_ON_FLAG_DELAYED && !tk));
    if (!dl && tk)
      chk(target_o, tgt);
    if (o == BCU_OP_LOOP_ADD)
    begin
      chk(wb_valid_o, 32'(!ta));
      if (!ta)
        chk(wb_data_o, sum);
      chk(loop_trap_indicator_o, 32'(ta));
      if (ta)
        chk(resume_pc_o, p);
    end
    @(posedge clock_i);
    instr_valid_i <= 1'b0;
    trap_i <= 1'b0;
    @(negedge clock_i);
    went = redirect_o;
    chk(redirect_o, 32'(dl && tk));
    if (dl && tk)
      chk(target_o, tgt);
    if (o == BCU_OP_LOOP_ADD)
    begin
      if (!ta && !ts)
        lf = !sum[31];
      chk(loop_condition_flag_o, 32'(lf));
      if (ts)
        chk(resume_pc_o, p);
    end
  endtask

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial
  begin
    #20000;
    err_count++;
    give_verdict();
  end

  initial
  begin
    void'($urandom(32'h8a36_6821));
    repeat (3) @(posedge clock_i);
    reset_i <= 1'b0;
    @(negedge clock_i);
    chk(redirect_o, 0);
    chk(annul_o, 0);
    chk(wb_valid_o, 0);
    chk(loop_condition_flag_o, 0);
    chk(loop_trap_indicator_o, 0);
    chk(target_o, 32'h0000_0000);
    chk(resume_pc_o, 32'h0000_0000);
    chk(wb_data_o, 32'h0000_0000);
    $display("test reset done");
    for (int i = 0; i < 48; i++)
    begin
      a = $urandom;
      xfer(bcu_op_t'(3'(i % 6 + 1)), 1'($urandom), 1'($urandom), a, i[3] ? a : $urandom, 1'b0, 1'b0);
    end
    $display("test all kinds done");
    for (int i = 0; i < 4; i++)
    begin
      xfer(BCU_OP_LOOP_ADD, 1'b0, 1'b0, $urandom, $urandom, 1'b0, 1'b0);
      xfer(BCU_OP_LOOP_ADD, 1'b0, 1'b0, $urandom, $urandom, i[0], !i[0]);
    end
    $display("test loop traps done");
    n = 3 + ($urandom & 3);
    cnt = n;
    xfer(BCU_OP_LOOP_ADD, 1'b0, 1'b0, 32'hffff_ffff, cnt, 1'b0, 1'b0);
    cnt = cnt - 32'h0000_0001;
    it = 0;
    do
    begin
      it++;
      xfer(BCU_OP_LOOP_ADD, 1'b0, 1'b0, 32'hffff_ffff, cnt, 1'b0, 1'b0);
      cnt = cnt - 32'h0000_0001;
    end
    while (went === 1'b1 && it < 20);
    chk(it, n + 1);
    $display("test counted loop done");
    give_verdict();
  end
endmodule
`default_nettype wire
